// >>> design/bus_mode_pkg.sv
package bus_mode_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [19:0] BUS_MODE_CONTROL_ADDR = 20'hF0231;
  localparam logic [19:0] SCL_LOW_WIDTH_ADDR    = 20'hF0232;
  localparam logic [19:0] SCL_HIGH_WIDTH_ADDR   = 20'hF0233;
  localparam logic [19:0] PORT_DIRECTION_ADDR   = 20'hF0234;
  localparam logic [19:0] PORT_LATCH_ADDR       = 20'hF0235;
  // ---------------------------------------------------------------
  // Field positions of bus_mode_control, and pin bits of the port registers
  // ---------------------------------------------------------------
  localparam int WAKEUP_ENABLE_BIT    = 7;
  localparam int CLOCK_LINE_LEVEL_BIT = 5;
  localparam int DATA_LINE_LEVEL_BIT  = 4;
  localparam int SPEED_SELECT_BIT     = 3;
  localparam int NOISE_FILTER_ON_BIT  = 2;
  localparam int CLOCK_PIN_BIT        = 0;
  localparam int DATA_PIN_BIT         = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCL_LOW_WIDTH_RESET    = 8'hFF;
  localparam logic [7:0] SCL_HIGH_WIDTH_RESET   = 8'hFF;
  localparam logic [7:0] PORT_DIRECTION_RESET   = 8'hFF;
  localparam logic [7:0] PORT_LATCH_RESET       = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ       = 25000000;
  localparam int FILTER_DEPTH      = 3;
  localparam int RISE_FALL_TIME_NS = 40;
  localparam int RISE_FALL_CYCLES  =
    (RISE_FALL_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
endpackage

// >>> design/line_filter.sv
`timescale 1ns/1ps
module line_filter #(
  parameter int DEPTH = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic line_in,
  output logic      line_out
);
  // ---------------------------------------------------------------
  // Majority-free glitch filter: output moves only after DEPTH
  // equal samples; when disabled the input passes after one flop.
  // ---------------------------------------------------------------
  logic [DEPTH-1:0] history;
  logic [DEPTH-1:0] next_history;
  logic             next_line_out;

  initial begin
    if (DEPTH < 2) begin
      $error("line_filter needs DEPTH of at least 2");
    end
  end

  always_comb begin
    next_history  = {history[DEPTH-2:0], line_in};
    next_line_out = line_out;
    if (!enable) begin
      next_line_out = line_in;
    end else if (&next_history) begin
      next_line_out = 1'b1;
    end else if (~|next_history) begin
      next_line_out = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      history  <= '1;
      line_out <= 1'b1;
    end else begin
      history  <= next_history;
      line_out <= next_line_out;
    end
  end
endmodule

// >>> design/bus_mode_control.sv
// Summary of operation
// - Mode control register resets to zero; bits 6, 1, 0 read zero.
// - Clock level bit follows clock pin; zero when disabled or reset.
// - Data level bit follows data pin; zero when disabled or reset.
// - Wakeup bit keeps address-match wakeup running in stop mode.
// - Match interrupt timing is unchanged by wakeup, bar sampling delay.
// - Stop-condition interrupt is suppressed while wakeup is set.
// - Non-interrupt wakeup clear blocks master until start or stop seen.
// - Speed bit: zero standard mode, one fast mode.
// - Filter bit enables input noise filter, fast mode only.
// - Low-width register sets driven clock low time; resets to ones.
// - High-width register sets driven clock high time; resets to ones.
// - While disabled, a bus pin in output mode drives a fixed low level.
// - Direction bit zero outputs, one inputs; register resets to ones.
// - Transfer clock is clock over low plus high plus rise-fall.
`timescale 1ns/1ps
module bus_mode_control
  import bus_mode_pkg::*;
#(
  parameter int RISE_FALL = RISE_FALL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [19:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        interface_enable,
  input  wire logic        stop_mode,
  input  wire logic        clock_gen_active,
  input  wire logic        match_event,
  input  wire logic        stop_event,
  input  wire logic        start_event,
  input  wire logic        interface_irq,
  input  wire logic        stop_interrupt_enable,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  input  wire logic        engine_clock_low,
  input  wire logic        engine_data_low,
  output logic             serial_clock_oe,
  output logic             serial_clock_out,
  output logic             serial_data_oe,
  output logic             serial_data_out,
  output logic             filtered_clock,
  output logic             filtered_data,
  output logic             speed_select,
  output logic             wakeup_enable,
  output logic             wakeup_request,
  output logic             match_irq,
  output logic             stop_irq,
  output logic             master_allowed,
  output logic             transfer_clock_tick
);
  initial begin
    if (RISE_FALL < 0 || RISE_FALL > 255) begin
      $error("RISE_FALL out of range");
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic       noise_filter_on;
  logic [7:0] scl_low_width;
  logic [7:0] scl_high_width;
  logic [7:0] port_direction;
  logic [7:0] port_latch;
  logic       master_block;
  logic       next_wakeup_enable;
  logic       next_speed_select;
  logic       next_noise_filter_on;
  logic [7:0] next_scl_low_width;
  logic [7:0] next_scl_high_width;
  logic [7:0] next_port_direction;
  logic [7:0] next_port_latch;
  logic       next_master_block;
  logic [7:0] next_reg_rdata;
  logic       clock_line_level;
  logic       data_line_level;
  logic       next_clock_line_level;
  logic       next_data_line_level;
  logic       filter_enable;

  always_comb begin
    next_wakeup_enable   = wakeup_enable;
    next_speed_select    = speed_select;
    next_noise_filter_on = noise_filter_on;
    next_scl_low_width   = scl_low_width;
    next_scl_high_width  = scl_high_width;
    next_port_direction  = port_direction;
    next_port_latch      = port_latch;
    next_master_block    = master_block;
    if (reg_write) begin
      unique case (reg_addr)
        BUS_MODE_CONTROL_ADDR: begin
          next_wakeup_enable   = reg_wdata[WAKEUP_ENABLE_BIT];
          next_speed_select    = reg_wdata[SPEED_SELECT_BIT];
          next_noise_filter_on = reg_wdata[NOISE_FILTER_ON_BIT];
        end
        SCL_LOW_WIDTH_ADDR:  next_scl_low_width  = reg_wdata;
        SCL_HIGH_WIDTH_ADDR: next_scl_high_width = reg_wdata;
        PORT_DIRECTION_ADDR: next_port_direction = reg_wdata;
        PORT_LATCH_ADDR:     next_port_latch     = reg_wdata;
        default: ;
      endcase
    end
    // A clear by software, not by an interface interrupt, locks out
    // master operation until the bus is seen to start or stop.
    // A bus event in the same cycle as the clear is not a later one,
    // so the lockout wins over it.
    if (start_event || stop_event) begin
      next_master_block = 1'b0;
    end
    if (wakeup_enable && !next_wakeup_enable && !interface_irq) begin
      next_master_block = 1'b1;
    end
  end

  // Level bits take the filtered line and clear while disabled.
  always_comb begin
    next_clock_line_level = interface_enable & filtered_clock;
    next_data_line_level  = interface_enable & filtered_data;
  end

  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        BUS_MODE_CONTROL_ADDR: begin
          next_reg_rdata[WAKEUP_ENABLE_BIT]    = wakeup_enable;
          next_reg_rdata[CLOCK_LINE_LEVEL_BIT] = clock_line_level;
          next_reg_rdata[DATA_LINE_LEVEL_BIT]  = data_line_level;
          next_reg_rdata[SPEED_SELECT_BIT]     = speed_select;
          next_reg_rdata[NOISE_FILTER_ON_BIT]  = noise_filter_on;
        end
        SCL_LOW_WIDTH_ADDR:  next_reg_rdata = scl_low_width;
        SCL_HIGH_WIDTH_ADDR: next_reg_rdata = scl_high_width;
        PORT_DIRECTION_ADDR: next_reg_rdata = port_direction;
        PORT_LATCH_ADDR:     next_reg_rdata = port_latch;
        default:             next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeup_enable    <= BUS_MODE_CONTROL_RESET[WAKEUP_ENABLE_BIT];
      speed_select     <= BUS_MODE_CONTROL_RESET[SPEED_SELECT_BIT];
      noise_filter_on  <= BUS_MODE_CONTROL_RESET[NOISE_FILTER_ON_BIT];
      scl_low_width    <= SCL_LOW_WIDTH_RESET;
      scl_high_width   <= SCL_HIGH_WIDTH_RESET;
      port_direction   <= PORT_DIRECTION_RESET;
      port_latch       <= PORT_LATCH_RESET;
      master_block     <= 1'b0;
      reg_rdata        <= 8'h00;
      clock_line_level <= 1'b0;
      data_line_level  <= 1'b0;
    end else begin
      wakeup_enable    <= next_wakeup_enable;
      speed_select     <= next_speed_select;
      noise_filter_on  <= next_noise_filter_on;
      scl_low_width    <= next_scl_low_width;
      scl_high_width   <= next_scl_high_width;
      port_direction   <= next_port_direction;
      port_latch       <= next_port_latch;
      master_block     <= next_master_block;
      reg_rdata        <= next_reg_rdata;
      clock_line_level <= next_clock_line_level;
      data_line_level  <= next_data_line_level;
    end
  end

  // ---------------------------------------------------------------
  // Input noise filters
  // ---------------------------------------------------------------
  assign filter_enable = noise_filter_on & speed_select;

  line_filter #(.DEPTH(FILTER_DEPTH)) clock_filter (
    .clk      (clk),
    .rst      (rst),
    .enable   (filter_enable),
    .line_in  (serial_clock_in),
    .line_out (filtered_clock)
  );

  line_filter #(.DEPTH(FILTER_DEPTH)) data_filter (
    .clk      (clk),
    .rst      (rst),
    .enable   (filter_enable),
    .line_in  (serial_data_in),
    .line_out (filtered_data)
  );

  // ---------------------------------------------------------------
  // Transfer clock generation
  // ---------------------------------------------------------------
  // Low phase lasts low width, high phase high width plus the line
  // rise and fall allowance, so one period is their sum.
  logic [8:0] phase_count;
  logic [8:0] next_phase_count;
  logic       clock_phase_high;
  logic       next_clock_phase_high;
  logic       next_tick;
  logic [8:0] high_span;

  assign high_span = 9'(scl_high_width) + 9'(RISE_FALL);

  always_comb begin
    next_phase_count      = phase_count + 9'h001;
    next_clock_phase_high = clock_phase_high;
    next_tick             = 1'b0;
    if (!interface_enable || !clock_gen_active) begin
      next_phase_count      = 9'h000;
      next_clock_phase_high = 1'b0;
    end else if (!clock_phase_high &&
                 next_phase_count >= 9'(scl_low_width)) begin
      next_phase_count      = 9'h000;
      next_clock_phase_high = 1'b1;
    end else if (clock_phase_high && next_phase_count >= high_span) begin
      next_phase_count      = 9'h000;
      next_clock_phase_high = 1'b0;
      next_tick             = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_count         <= 9'h000;
      clock_phase_high    <= 1'b0;
      transfer_clock_tick <= 1'b0;
    end else begin
      phase_count         <= next_phase_count;
      clock_phase_high    <= next_clock_phase_high;
      transfer_clock_tick <= next_tick;
    end
  end

  // ---------------------------------------------------------------
  // Pins, wakeup and interrupts
  // ---------------------------------------------------------------
  logic next_clock_oe;
  logic next_clock_out;
  logic next_data_oe;
  logic next_data_out;
  logic next_wakeup_request;
  logic next_match_irq;
  logic next_stop_irq;
  logic next_master_allowed;
  logic clock_drive_low;

  assign clock_drive_low = engine_clock_low |
                           (clock_gen_active & ~clock_phase_high);

  always_comb begin
    // While disabled, an output-mode pin is held low.
    next_clock_oe  = ~port_direction[CLOCK_PIN_BIT];
    next_data_oe   = ~port_direction[DATA_PIN_BIT];
    next_clock_out = 1'b0;
    next_data_out  = 1'b0;
    // Open drain: release the pin unless it must be pulled low.
    if (interface_enable) begin
      next_clock_oe = next_clock_oe & (clock_drive_low |
                                       port_latch[CLOCK_PIN_BIT]);
      next_data_oe  = next_data_oe & (engine_data_low |
                                      port_latch[DATA_PIN_BIT]);
    end
    // Wakeup and interrupt outputs follow their causes by one cycle.
    next_wakeup_request = stop_mode & wakeup_enable & match_event;
    next_match_irq      = match_event;
    next_stop_irq       = stop_event & stop_interrupt_enable &
                          ~wakeup_enable;
    next_master_allowed = interface_enable & ~master_block;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_clock_oe  <= 1'b0;
      serial_clock_out <= 1'b0;
      serial_data_oe   <= 1'b0;
      serial_data_out  <= 1'b0;
      wakeup_request   <= 1'b0;
      match_irq        <= 1'b0;
      stop_irq         <= 1'b0;
      master_allowed   <= 1'b0;
    end else begin
      serial_clock_oe  <= next_clock_oe;
      serial_clock_out <= next_clock_out;
      serial_data_oe   <= next_data_oe;
      serial_data_out  <= next_data_out;
      wakeup_request   <= next_wakeup_request;
      match_irq        <= next_match_irq;
      stop_irq         <= next_stop_irq;
      master_allowed   <= next_master_allowed;
    end
  end
endmodule

// >>> verif/bus_mode_control_properties.sv
`timescale 1ns/1ps
module bus_mode_control_props
  import bus_mode_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [19:0] reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        interface_enable,
  input wire logic        match_event,
  input wire logic        stop_event,
  input wire logic        interface_irq,
  input wire logic        stop_interrupt_enable,
  input wire logic        speed_select,
  input wire logic        wakeup_enable,
  input wire logic        wakeup_request,
  input wire logic        match_irq,
  input wire logic        stop_irq
);
  wire mode_wr = reg_write && reg_addr == BUS_MODE_CONTROL_ADDR;
  wire mode_rd = reg_read && reg_addr == BUS_MODE_CONTROL_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Mode register and event relations
  // ---------------------------------------------------------------
  property p_unused;
    mode_rd |=> reg_rdata[6] == 1'b0 && reg_rdata[1:0] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_level_off;
    (!interface_enable)[*6] ##0 mode_rd |=> reg_rdata[5:4] == 2'b00;
  endproperty
  a_level_off: assert property (p_level_off) else $error("level bit");
  property p_speed;
    mode_wr |=> speed_select == $past(reg_wdata[SPEED_SELECT_BIT]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit wrong");
  property p_wake_wr;
    mode_wr && !interface_irq |=>
      wakeup_enable == $past(reg_wdata[WAKEUP_ENABLE_BIT]);
  endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("wakeup bit");
  property p_wake_gate;
    wakeup_request |-> $past(wakeup_enable);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake req");
  property p_match;
    match_event && interface_enable |=> match_irq;
  endproperty
  a_match: assert property (p_match) else $error("match irq missing");
  property p_stop_irq;
    stop_event && stop_interrupt_enable && !wakeup_enable |=> stop_irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop irq");
  property p_stop_mask;
    wakeup_enable |=> !stop_irq;
  endproperty
  a_stop_mask: assert property (p_stop_mask) else $error("stop masked");
endmodule

bind bus_mode_control bus_mode_control_props bus_mode_control_props_inst (
  .clk, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
  .interface_enable, .match_event, .stop_event, .interface_irq,
  .stop_interrupt_enable, .speed_select, .wakeup_enable, .wakeup_request,
  .match_irq, .stop_irq
);

// >>> verif/bus_far_side.sv
`timescale 1ns/1ps
module bus_far_side (
  input  wire logic clk,
  input  wire logic clock_oe,
  input  wire logic clock_out,
  input  wire logic data_oe,
  input  wire logic data_out,
  input  wire logic hold_clock_low,
  input  wire logic hold_data_low,
  output logic      serial_clock,
  output logic      serial_data
);
  logic clock_low_q = 1'b0;
  logic data_low_q  = 1'b0;
  // ---------------------------------------------------------------
  // Open-drain lines with pull-ups
  // ---------------------------------------------------------------
  // Other bus parties change their pulls just after a clock edge.
  always_ff @(posedge clk) begin
    clock_low_q <= hold_clock_low;
    data_low_q  <= hold_data_low;
  end
  // Any party pulling low wins; a released line goes to the pull-up.
  assign serial_clock = !((clock_oe && !clock_out) || clock_low_q);
  assign serial_data  = !((data_oe && !data_out) || data_low_q);
endmodule

// >>> verif/bus_mode_control_tb.sv
`timescale 1ns/1ps
module bus_mode_control_tb
  import bus_mode_pkg::*;
;
  typedef struct packed {
    logic [19:0] addr;
    logic        wr;
    logic [7:0]  data;
    logic [7:0]  exp;
  } row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [19:0] reg_addr = 20'h00000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, got;
  logic reg_write = 1'b0, reg_read = 1'b0, interface_enable = 1'b0;
  logic stop_mode = 1'b0, clock_gen_active = 1'b0, match_event = 1'b0;
  logic stop_event = 1'b0, start_event = 1'b0, interface_irq = 1'b0;
  logic stop_interrupt_enable = 1'b0, engine_clock_low = 1'b0;
  logic engine_data_low = 1'b0, hold_clock_low = 1'b0;
  logic hold_data_low = 1'b0, seen, serial_clock, serial_data;
  logic serial_clock_oe, serial_clock_out, serial_data_oe, serial_data_out;
  logic filtered_clock, filtered_data, speed_select, wakeup_enable;
  logic wakeup_request, match_irq, stop_irq, master_allowed;
  logic transfer_clock_tick;
  int   mismatches = 0, comparisons = 0, n;
  row_t rows [11] = '{
    '{BUS_MODE_CONTROL_ADDR, 1'b0, 8'h00, 8'h00},
    '{SCL_LOW_WIDTH_ADDR, 1'b0, 8'h00, 8'hFF},
    '{SCL_HIGH_WIDTH_ADDR, 1'b0, 8'h00, 8'hFF},
    '{PORT_DIRECTION_ADDR, 1'b0, 8'h00, 8'hFF},
    '{PORT_LATCH_ADDR, 1'b0, 8'h00, 8'h00},
    '{BUS_MODE_CONTROL_ADDR, 1'b1, 8'hFF, 8'h8C},
    '{BUS_MODE_CONTROL_ADDR, 1'b1, 8'h00, 8'h00},
    '{SCL_LOW_WIDTH_ADDR, 1'b1, 8'h1A, 8'h1A},
    '{SCL_HIGH_WIDTH_ADDR, 1'b1, 8'h25, 8'h25},
    '{PORT_DIRECTION_ADDR, 1'b1, 8'h1C, 8'h1C},
    '{20'hF0236, 1'b1, 8'h55, 8'h00}
  };
  bus_mode_control #(.RISE_FALL(1)) bus_mode_control_inst (
    .clk, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .interface_enable, .stop_mode, .clock_gen_active, .match_event,
    .stop_event, .start_event, .interface_irq, .stop_interrupt_enable,
    .serial_clock_in(serial_clock), .serial_data_in(serial_data),
    .engine_clock_low, .engine_data_low, .serial_clock_oe, .serial_clock_out,
    .serial_data_oe, .serial_data_out, .filtered_clock, .filtered_data,
    .speed_select, .wakeup_enable, .wakeup_request, .match_irq, .stop_irq,
    .master_allowed, .transfer_clock_tick
  );
  bus_far_side bus_far_side_inst (
    .clk, .clock_oe(serial_clock_oe), .clock_out(serial_clock_out),
    .data_oe(serial_data_oe), .data_out(serial_data_out), .hold_clock_low,
    .hold_data_low, .serial_clock, .serial_data
  );
  always #20 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus cycles, comparisons and closing
  // ---------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, act);
    comparisons++;
    if (act !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic chk1(input string what, input logic exp, act);
    chk8(what, {7'h00, exp}, {7'h00, act});
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    got = reg_rdata;
  endtask
  task automatic mode(input logic [7:0] d);
    interface_enable = 1'b0;
    wr(BUS_MODE_CONTROL_ADDR, d);
    interface_enable = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic fire(input logic [2:0] s);
    @(negedge clk);
    {start_event, stop_event, match_event} = s;
    @(negedge clk);
    {start_event, stop_event, match_event} = 3'b000;
  endtask
  task automatic glitch();
    seen = 1'b0;
    @(negedge clk);
    hold_data_low = 1'b1;
    @(negedge clk);
    hold_data_low = 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (filtered_data !== 1'b1) seen = 1'b1;
    end
  endtask
  task automatic period();
    for (int i = 0; i < 200 && transfer_clock_tick !== 1'b1; i++) begin
      @(negedge clk);
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (transfer_clock_tick !== 1'b1 && n < 200);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    test_done();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk1("clock_oe", 1'b0, serial_clock_oe);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end
      rd(rows[i].addr);
      chk8("register", rows[i].exp, got);
    end
    chk1("clock_oe", 1'b1, serial_clock_oe);
    chk1("data_oe", 1'b1, serial_data_oe);
    chk1("clock_out", 1'b0, serial_clock_out);
    chk1("data_out", 1'b0, serial_data_out);
    interface_enable = 1'b1;
    repeat (8) @(negedge clk);
    chk1("data_oe", 1'b0, serial_data_oe);
    rd(BUS_MODE_CONTROL_ADDR);
    chk8("levels", 8'h30, got);
    hold_data_low = 1'b1;
    repeat (8) @(negedge clk);
    rd(BUS_MODE_CONTROL_ADDR);
    chk8("levels", 8'h20, got);
    engine_clock_low = 1'b1;
    repeat (8) @(negedge clk);
    chk1("clock_oe", 1'b1, serial_clock_oe);
    chk1("filtered_clock", 1'b0, filtered_clock);
    rd(BUS_MODE_CONTROL_ADDR);
    chk8("levels", 8'h00, got);
    engine_clock_low = 1'b0;
    hold_data_low = 1'b0;
    clock_gen_active = 1'b1;
    mode(8'h0C);
    chk1("speed", 1'b1, speed_select);
    glitch();
    chk1("glitch", 1'b0, seen);
    period();
    chk8("period", 8'h1A + 8'h25 + 8'h01, 8'(n));
    mode(8'h04);
    chk1("speed", 1'b0, speed_select);
    glitch();
    chk1("glitch", 1'b1, seen);
    period();
    chk8("period", 8'h1A + 8'h25 + 8'h01, 8'(n));
    stop_interrupt_enable = 1'b1;
    wr(BUS_MODE_CONTROL_ADDR, 8'h84);
    repeat (3) @(negedge clk);
    stop_mode = 1'b1;
    fire(3'b010);
    chk1("stop_irq", 1'b0, stop_irq);
    fire(3'b001);
    chk1("match_irq", 1'b1, match_irq);
    chk1("wakeup_request", 1'b1, wakeup_request);
    stop_mode = 1'b0;
    wr(BUS_MODE_CONTROL_ADDR, 8'h04);
    repeat (3) @(negedge clk);
    chk1("master_allowed", 1'b0, master_allowed);
    fire(3'b100);
    repeat (2) @(negedge clk);
    chk1("master_allowed", 1'b1, master_allowed);
    wr(BUS_MODE_CONTROL_ADDR, 8'h84);
    interface_irq = 1'b1;
    wr(BUS_MODE_CONTROL_ADDR, 8'h04);
    interface_irq = 1'b0;
    repeat (2) @(negedge clk);
    chk1("master_allowed", 1'b1, master_allowed);
    stop_mode = 1'b1;
    fire(3'b011);
    chk1("stop_irq", 1'b1, stop_irq);
    chk1("wakeup_request", 1'b0, wakeup_request);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(SCL_LOW_WIDTH_ADDR);
    chk8("low width", 8'hFF, got);
    test_done();
  end
endmodule
